/* hdl/qfc_counter.sv */
// Quadrature free-running position counter with an APB register slave.
`timescale 1ns/1ps
`default_nettype none
`include "qfc_cfg.svh"
module qfc_counter
  import qfc_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  // Encoder phases.
  input wire logic phaseA,
  input wire logic phaseB,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Status outputs.
  output logic [31:0] countValue,
  output logic wrapFlag,
  output logic captureFlag,
  output logic running
);
  logic [1:0] syncA;
  logic [1:0] syncB;
  logic prevA;
  logic prevB;
  // Action bits 6:0 and the two mode bits; the unused bus bit 7 is not stored.
  logic [`QFC_MODE_LSB:0] ctrl;
  logic [1:0] modeSel;
  logic [31:0] captureValue;
  logic th0Reached;
  logic th1Reached;
  logic [`QFC_MODE_LSB:0] prevCtrl;
  logic [31:0] memRead;
  logic [31:0] preset;
  logic [31:0] threshold0;
  logic [31:0] threshold1;
  logic readPending;
  logic readFromMem;
  logic [31:0] localRead;
  qfc_step_t step;
  qfc_mode_t mode;

  wire apbSetup = psel && !penable;
  wire apbAccess = psel && penable && pready;
  wire apbWrite = apbAccess && pwrite;

  // Rising edge of a software control bit.
  function automatic logic ctrlRise(input logic [`QFC_MODE_LSB:0] now,
    input logic [`QFC_MODE_LSB:0] old, input int b);
    ctrlRise = now[b] && !old[b];
  endfunction

  // Parameter slot for a bus address; slot 0 is preset.
  function automatic logic [2:0] paramSlot(input logic [11:0] a);
    case (a)
      `QFC_OFS_PRESET: paramSlot = 3'b100;
      `QFC_OFS_WRAP: paramSlot = 3'b101;
      `QFC_OFS_TH0: paramSlot = 3'b110;
      `QFC_OFS_TH1: paramSlot = 3'b111;
      default: paramSlot = 3'b000;
    endcase
  endfunction

  wire syncRise = ctrlRise(ctrl, prevCtrl, `QFC_BIT_SYNC);
  wire presetRise = ctrlRise(ctrl, prevCtrl, `QFC_BIT_PRESET);
  wire captureRise = ctrlRise(ctrl, prevCtrl, `QFC_BIT_CAPTURE);
  wire wrapAckRise = ctrlRise(ctrl, prevCtrl, `QFC_BIT_WRAPACK);
  wire capAckRise = ctrlRise(ctrl, prevCtrl, `QFC_BIT_CAPACK);
  wire restore = ctrlRise(ctrl, prevCtrl, `QFC_BIT_RESTORE);
  wire [2:0] wrSlot = paramSlot(paddr);

  qfc_param_mem u_mem (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .restore(restore),
    .writeEn(apbWrite && wrSlot[2]),
    .writeSel(wrSlot[1:0]),
    .writeData(pwdata),
    .readSel(wrSlot[1:0]),
    .readData(memRead),
    .preset(preset),
    // The wrap value is kept for software only; the count always wraps at the full range.
    .wrapValue(),
    .threshold0(threshold0),
    .threshold1(threshold1)
  );

  // Two-flop synchronisers; only the second stage feeds the decoder.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      syncA <= 2'b00;
      syncB <= 2'b00;
      prevA <= 1'b0;
      prevB <= 1'b0;
    end
    else
    begin
      syncA <= {syncA[0], phaseA};
      syncB <= {syncB[0], phaseB};
      prevA <= syncA[1];
      prevB <= syncB[1];
    end
  end

  assign modeSel = ctrl[`QFC_MODE_LSB -: 2];
  assign mode = qfc_mode_t'(modeSel);

  // Quadrature decode. Double resolution counts only A edges, which gives two
  // counts per cycle while still resolving direction from B.
  always_comb
  begin
    logic edgeA;
    logic edgeB;
    logic up;
    logic swapped;
    logic quad;
    edgeA = syncA[1] ^ prevA;
    edgeB = syncB[1] ^ prevB;
    swapped = (mode == QFC_SWP_X2) || (mode == QFC_SWP_X4);
    quad = (mode == QFC_FWD_X4) || (mode == QFC_SWP_X4);
    up = 1'b0;
    step = QFC_STEP_NONE;
    if (edgeA && !edgeB)
    begin
      up = syncA[1] ^ syncB[1];
      step = up ? QFC_STEP_UP : QFC_STEP_DOWN;
    end
    else if (edgeB && !edgeA && quad)
    begin
      up = !(syncA[1] ^ syncB[1]);
      step = up ? QFC_STEP_UP : QFC_STEP_DOWN;
    end
    if (swapped && step == QFC_STEP_UP)
      step = QFC_STEP_DOWN;
    else if (swapped && step == QFC_STEP_DOWN)
      step = QFC_STEP_UP;
  end

  // Counter. Sync and preset take priority over a simultaneous encoder step.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      countValue <= `QFC_ZERO32;
      running <= 1'b0;
    end
    else if (syncRise)
    begin
      countValue <= preset;
      running <= 1'b1;
    end
    else if (presetRise)
      countValue <= preset;
    else if (running && ctrl[`QFC_BIT_ENABLE])
    begin
      if (step == QFC_STEP_UP)
        countValue <= (countValue == `QFC_COUNT_MAX) ? `QFC_COUNT_MIN : countValue + 32'h1;
      else if (step == QFC_STEP_DOWN)
        countValue <= (countValue == `QFC_COUNT_MIN) ? `QFC_COUNT_MAX : countValue - 32'h1;
    end
  end

  wire counting = running && ctrl[`QFC_BIT_ENABLE] && !syncRise && !presetRise;
  wire wrapEvent = counting && ((step == QFC_STEP_UP && countValue == `QFC_COUNT_MAX)
    || (step == QFC_STEP_DOWN && countValue == `QFC_COUNT_MIN));

  // Wrap flag; a wrap in the acknowledge cycle wins.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      wrapFlag <= 1'b0;
    else if (wrapEvent)
      wrapFlag <= 1'b1;
    else if (wrapAckRise)
      wrapFlag <= 1'b0;
  end

  // Capture; refused while the done flag is still set.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      captureValue <= `QFC_ZERO32;
      captureFlag <= 1'b0;
    end
    else if (captureRise && !captureFlag)
    begin
      captureValue <= countValue;
      captureFlag <= 1'b1;
    end
    else if (capAckRise)
      captureFlag <= 1'b0;
  end

  // Threshold status as signed compares.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      th0Reached <= 1'b0;
      th1Reached <= 1'b0;
    end
    else
    begin
      th0Reached <= $signed(countValue) >= $signed(threshold0);
      th1Reached <= $signed(countValue) >= $signed(threshold1);
    end
  end

  // Control register and its edge history.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      ctrl <= '0;
      prevCtrl <= '0;
    end
    else
    begin
      prevCtrl <= ctrl;
      if (apbWrite && paddr == `QFC_OFS_CTRL)
        ctrl <= {pwdata[`QFC_MODE_LSB+1 -: 2], pwdata[`QFC_BIT_RESTORE:0]};
    end
  end

  // Register read mux for locally held registers.
  always_comb
  begin
    localRead = `QFC_ZERO32;
    case (paddr)
      `QFC_OFS_CTRL: localRead = {22'h0, ctrl[`QFC_MODE_LSB -: 2], 1'b0, ctrl[`QFC_BIT_RESTORE:0]};
      `QFC_OFS_STATUS: localRead = {27'h0, th1Reached, th0Reached, captureFlag, wrapFlag, running};
      `QFC_OFS_COUNT: localRead = countValue;
      `QFC_OFS_CAPTURE: localRead = captureValue;
      default: localRead = `QFC_ZERO32;
    endcase
  end

  // APB: one wait state so the parameter store's registered read is ready.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      pready <= 1'b0;
      prdata <= `QFC_ZERO32;
      pslverr <= 1'b0;
      readPending <= 1'b0;
      readFromMem <= 1'b0;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      if (apbSetup)
      begin
        readPending <= 1'b1;
        readFromMem <= wrSlot[2];
        prdata <= localRead;
      end
      else if (readPending && psel && penable)
      begin
        readPending <= 1'b0;
        pready <= 1'b1;
        if (readFromMem)
          prdata <= memRead;
        pslverr <= !(wrSlot[2] || paddr == `QFC_OFS_CTRL || paddr == `QFC_OFS_STATUS
          || paddr == `QFC_OFS_COUNT || paddr == `QFC_OFS_CAPTURE);
      end
    end
  end
endmodule
`default_nettype wire

/* hdl/qfc_cfg.svh */
// Constant definitions for the quadrature free-running counter.
`ifndef QFC_CFG_SVH
`define QFC_CFG_SVH
`define QFC_OFS_CTRL 12'h000
`define QFC_OFS_STATUS 12'h004
`define QFC_OFS_PRESET 12'h008
`define QFC_OFS_WRAP 12'h00c
`define QFC_OFS_TH0 12'h010
`define QFC_OFS_TH1 12'h014
`define QFC_OFS_COUNT 12'h018
`define QFC_OFS_CAPTURE 12'h01c
`define QFC_BIT_ENABLE 0
`define QFC_BIT_SYNC 1
`define QFC_BIT_PRESET 2
`define QFC_BIT_CAPTURE 3
`define QFC_BIT_WRAPACK 4
`define QFC_BIT_CAPACK 5
`define QFC_BIT_RESTORE 6
`define QFC_MODE_LSB 8
`define QFC_BIT_RUN 0
`define QFC_BIT_WRAPFLAG 1
`define QFC_BIT_CAPFLAG 2
`define QFC_BIT_TH0 3
`define QFC_BIT_TH1 4
`define QFC_RST_PRESET 32'h0000_0000
`define QFC_RST_WRAP 32'h7fff_ffff
`define QFC_RST_TH0 32'h0000_0064
`define QFC_RST_TH1 32'h0000_00c8
`define QFC_COUNT_MIN 32'h8000_0000
`define QFC_COUNT_MAX 32'h7fff_ffff
`define QFC_ZERO32 32'h0000_0000
`endif

/* hdl/qfc_pkg.sv */
// Types shared by the quadrature free-running counter.
package qfc_pkg;
  typedef enum logic [1:0] {
    QFC_FWD_X2,
    QFC_FWD_X4,
    QFC_SWP_X2,
    QFC_SWP_X4
  } qfc_mode_t;
  typedef enum logic [1:0] {
    QFC_STEP_NONE,
    QFC_STEP_UP,
    QFC_STEP_DOWN
  } qfc_step_t;
endpackage

/* hdl/qfc_param_mem.sv */
// Small register store holding the run-time adjustable parameters.
`timescale 1ns/1ps
`default_nettype none
`include "qfc_cfg.svh"
module qfc_param_mem
  import qfc_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  // Restore request (cold or warm start).
  input wire logic restore,
  // Write port.
  input wire logic writeEn,
  input wire logic [1:0] writeSel,
  input wire logic [31:0] writeData,
  // Read port, registered.
  input wire logic [1:0] readSel,
  output logic [31:0] readData,
  // Live values.
  output logic [31:0] preset,
  output logic [31:0] wrapValue,
  output logic [31:0] threshold0,
  output logic [31:0] threshold1
);
  logic [31:0] store [4];
  localparam logic [31:0] INIT [4] = '{`QFC_RST_PRESET, `QFC_RST_WRAP, `QFC_RST_TH0, `QFC_RST_TH1};

  genvar i;
  generate
    for (i = 0; i < 4; i++)
    begin : g_word
      always_ff @(posedge clk_sys)
      begin
        if (!reset_n || restore)
          store[i] <= INIT[i];
        else if (writeEn && writeSel == i[1:0])
          store[i] <= writeData;
      end
    end
  endgenerate

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      readData <= `QFC_ZERO32;
    else
      readData <= store[readSel];
  end

  assign preset = store[0];
  assign wrapValue = store[1];
  assign threshold0 = store[2];
  assign threshold1 = store[3];
endmodule
`default_nettype wire

/* verif/qfc_counter_checker.sv */
// Port assertions for the quadrature counter.
`timescale 1ns/1ps
`default_nettype none
module qfc_counter_checker (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  // Bus and status.
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic [31:0] countValue,
  input wire logic wrapFlag,
  input wire logic captureFlag,
  input wire logic running
);
  logic [3:0] idle;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  // Bus writes load the count a few edges later, so step checks wait for a quiet bus.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n || psel)
      idle <= 4'h0;
    else if (idle != 4'hf)
      idle <= idle + 4'h1;
  end
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_ready_delay: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready late");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  a_read_hold: assert property (!psel |-> $stable(prdata))
    else $error("prdata moved");
  a_step_size: assert property (idle > 4'h6 |->
    (countValue - $past(countValue)) inside {32'h0, 32'h1, 32'hffff_ffff})
    else $error("count jumped");
  a_idle_hold: assert property (!running && idle > 4'h6 |-> $stable(countValue))
    else $error("count moved while stopped");
  a_run_sticky: assert property (running |=> running)
    else $error("running dropped");
  a_wrap_flag: assert property ($past(countValue) == 32'h7fff_ffff &&
    countValue == 32'h8000_0000 |-> ##[0:1] wrapFlag)
    else $error("wrap flag missing");
  a_wrap_sticky: assert property (wrapFlag && idle > 4'h3 |=> wrapFlag)
    else $error("wrap flag cleared");
  a_cap_sticky: assert property (captureFlag && idle > 4'h3 |=> captureFlag)
    else $error("capture flag cleared");
  c_wrap: cover property ($rose(wrapFlag));
  c_capture: cover property ($rose(captureFlag));
  c_refused: cover property (pslverr);
endmodule
bind qfc_counter qfc_counter_checker qfc_counter_checker_inst (.clk_sys(clk_sys),
  .reset_n(reset_n), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .prdata(prdata), .countValue(countValue), .wrapFlag(wrapFlag),
  .captureFlag(captureFlag), .running(running));
`default_nettype wire

/* verif/qfc_encoder_model.sv */
// Incremental encoder model driving the two phase inputs.
`timescale 1ns/1ps
`default_nettype none
module qfc_encoder_model (
  // Clock.
  input wire logic clk_sys,
  // Phases.
  output logic phaseA,
  output logic phaseB
);
  logic [1:0] pos = 2'h0;
  // Gray order 00, 10, 11, 01 lets A lead B when stepping up.
  assign phaseA = pos[1] ^ pos[0];
  assign phaseB = pos[1];
  // One phase edge per step; gap sets how fast the shaft turns.
  task automatic move(input int edges, input bit up, input int gap);
    repeat (edges)
    begin
      repeat (gap) @(posedge clk_sys);
      pos <= up ? pos + 2'h1 : pos - 2'h1;
    end
  endtask
endmodule
`default_nettype wire

/* verif/qfc_counter_tb_top.sv */
// Self-checking bench for the quadrature counter.
`timescale 1ns/1ps
`default_nettype none
`include "qfc_cfg.svh"
module qfc_counter_tb_top;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, countValue, rd, expC, exp, ctrlBase;
  logic pready, pslverr, wrapFlag, captureFlag, running, err, phaseA, phaseB;
  int fail_count = 0;
  int comparisons = 0;
  integer seed = 32'h2841414a;
  always #2 clk_sys = ~clk_sys;
  qfc_counter qfc_counter_inst (.clk_sys(clk_sys), .reset_n(reset_n), .phaseA(phaseA),
    .phaseB(phaseB), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .countValue(countValue), .wrapFlag(wrapFlag), .captureFlag(captureFlag),
    .running(running));
  qfc_encoder_model qfc_encoder_model_inst (.clk_sys(clk_sys), .phaseA(phaseA),
    .phaseB(phaseB));
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", name, want, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      fail_count++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0);
    chk(name, rd, want);
  endtask
  // Control actions fire on a written 0 to 1 step, so each pulse is set then cleared.
  task automatic ctl(input logic [31:0] bits);
    apb(1'b1, `QFC_OFS_CTRL, ctrlBase | bits);
    apb(1'b1, `QFC_OFS_CTRL, ctrlBase);
  endtask
  task automatic turn(input int edges, input bit up, input int gap);
    qfc_encoder_model_inst.move(edges, up, gap);
    repeat (5) @(posedge clk_sys);
  endtask
  initial
  begin
    ctrlBase = 32'h0;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    rdchk("preset", `QFC_OFS_PRESET, `QFC_RST_PRESET);
    rdchk("th0", `QFC_OFS_TH0, `QFC_RST_TH0);
    rdchk("th1", `QFC_OFS_TH1, `QFC_RST_TH1);
    rdchk("unmapped", 12'h020, 32'h0);
    chk("slverr", 32'(err), 32'h1);
    for (int i = 0; i < 3; i++)
    begin
      exp = $random(seed);
      apb(1'b1, `QFC_OFS_WRAP + 12'(4 * i), exp);
      rdchk("param", `QFC_OFS_WRAP + 12'(4 * i), exp);
    end
    ctl(32'h40);
    rdchk("wrap", `QFC_OFS_WRAP, `QFC_RST_WRAP);
    $display("parameter test done");
    apb(1'b1, `QFC_OFS_CTRL, 32'h1);
    turn(4, 1'b1, 1);
    chk("stopped", countValue, `QFC_ZERO32);
    for (int m = 0; m < 4; m++)
    begin
      ctrlBase = 32'h1 | 32'(m << 8);
      exp = $random(seed);
      apb(1'b1, `QFC_OFS_PRESET, exp);
      ctl(32'h2);
      chk("sync", countValue, exp);
      chk("running", 32'(running), 32'h1);
      turn(8, 1'b1, 1 + m);
      expC = exp + (m[1] ? -1 : 1) * (m[0] ? 8 : 4);
      chk("up", countValue, expC);
      turn(4, 1'b0, 1);
      expC = expC - (m[1] ? -1 : 1) * (m[0] ? 4 : 2);
      chk("down", countValue, expC);
    end
    $display("mode test done");
    ctrlBase = 32'h100;
    apb(1'b1, `QFC_OFS_CTRL, ctrlBase);
    turn(4, 1'b1, 1);
    chk("hold", countValue, expC);
    ctrlBase = 32'h101;
    exp = $random(seed);
    apb(1'b1, `QFC_OFS_PRESET, exp);
    ctl(32'h4);
    chk("preset", countValue, exp);
    ctl(32'h8);
    rdchk("capture", `QFC_OFS_CAPTURE, exp);
    chk("capflag", 32'(captureFlag), 32'h1);
    turn(4, 1'b1, 2);
    expC = exp + 4;
    ctl(32'h8);
    rdchk("refused", `QFC_OFS_CAPTURE, exp);
    chk("count", countValue, expC);
    ctl(32'h20);
    chk("capack", 32'(captureFlag), 32'h0);
    $display("capture test done");
    apb(1'b1, `QFC_OFS_PRESET, `QFC_COUNT_MAX);
    ctl(32'h14);
    turn(1, 1'b1, 1);
    chk("overflow", countValue, `QFC_COUNT_MIN);
    chk("wrapflag", 32'(wrapFlag), 32'h1);
    ctl(32'h10);
    chk("wrapack", 32'(wrapFlag), 32'h0);
    turn(1, 1'b0, 3);
    chk("underflow", countValue, `QFC_COUNT_MAX);
    chk("wrapflag", 32'(wrapFlag), 32'h1);
    rdchk("countreg", `QFC_OFS_COUNT, `QFC_COUNT_MAX);
    $display("wrap test done");
    finish_test();
  end
endmodule
`default_nettype wire
